// ---- design/esl_pkg.sv ----
package esl_pkg;
    // Timing
    localparam int         CLK_HZ     = 20_000_000;
    localparam int         BIT_RATE   = 2_500_000;
    localparam int         CLK_NS     = 50;
    localparam int         REPLY_NS   = 20_000;
    localparam int         BIT_CYC    = CLK_HZ / BIT_RATE;
    localparam logic [3:0] BIT_LAST   = 4'(BIT_CYC - 1);
    localparam logic [3:0] HALF_LAST  = 4'(BIT_CYC / 2 - 1);
    localparam logic [8:0] REPLY_LAST = 9'(REPLY_NS / CLK_NS - 1);
    localparam logic [8:0] TURN_LAST  = 9'(BIT_CYC - 1);
    // Byte framing: start, data, stop
    localparam int         DATA_BITS  = 8;
    localparam logic [2:0] DATA_LAST  = 3'(DATA_BITS - 1);
    localparam logic [3:0] FRAME_LAST = 4'(DATA_BITS + 1);
    localparam int         MAX_BYTES  = 11;
    // Command bytes
    localparam logic [7:0] CMD_POS    = 8'h02;
    localparam logic [7:0] CMD_TURNS  = 8'h8A;
    localparam logic [7:0] CMD_ID     = 8'h92;
    localparam logic [7:0] CMD_ALL    = 8'h1A;
    localparam logic [7:0] CMD_NV_WR  = 8'h32;
    localparam logic [7:0] CMD_NV_RD  = 8'hEA;
    // Identity of resolution variant
    localparam logic [7:0] ENID_17    = 8'h11;
    localparam logic [7:0] ENID_23    = 8'h17;
    // Nonvolatile map
    localparam logic [6:0] PAGE_ADDR  = 7'h7F;
    localparam logic [7:0] PAGE_MAX   = 8'h02;
    localparam logic [1:0] PAGE_RST   = 2'h0;
    localparam int         NV_WORDS   = 127;
    localparam int         PAGES      = 3;
    // Status byte bits; shift of the 17-bit position
    localparam int         SF_CNT_ERR = 4;
    localparam int         SF_MT_ERR  = 5;
    localparam int         ABS17_SHIFT = 6;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} esl_rx_st_t;
    typedef struct packed {
        esl_rx_st_t st;
        logic [3:0] cnt;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic       done;
        logic       ferr;
    } esl_rx_t;
    typedef struct packed {
        logic       busy;
        logic [3:0] cnt;
        logic [3:0] bitn;
        logic [9:0] sh;
        logic       done;
    } esl_tx_t;
    typedef logic [MAX_BYTES-1:0][7:0] esl_buf_t;

    // Bytes of a command frame, checksum included; zero for unknown codes
    function automatic logic [3:0] req_len(input logic [7:0] c);
        case (c)
            CMD_NV_WR: req_len = 4'h4;
            CMD_NV_RD: req_len = 4'h3;
            CMD_POS, CMD_TURNS, CMD_ID, CMD_ALL: req_len = 4'h2;
            default: req_len = 4'h0;
        endcase
    endfunction

    // Bytes of the reply frame, checksum included
    function automatic logic [3:0] rsp_len(input logic [7:0] c);
        case (c)
            CMD_POS: rsp_len = 4'h6;
            CMD_TURNS: rsp_len = 4'h5;
            CMD_ID: rsp_len = 4'h3;
            CMD_ALL: rsp_len = 4'hB;
            CMD_NV_WR, CMD_NV_RD: rsp_len = 4'h4;
            default: rsp_len = 4'h0;
        endcase
    endfunction

    // XOR of the bytes that precede the checksum slot
    function automatic logic [7:0] cksum(input esl_buf_t b, input logic [3:0] len);
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < MAX_BYTES; i++)
        begin
            if (4'(i) < len - 4'h1)
                x = x ^ b[i];
        end
        cksum = x;
    endfunction

    // One clock of the byte receiver; samples each bit at its middle
    function automatic esl_rx_t rx_step(input esl_rx_t s, input logic line);
        esl_rx_t r;
        r = s;
        r.done = 1'b0;
        r.ferr = 1'b0;
        r.cnt = s.cnt + 4'h1;
        case (s.st)
            RX_IDLE:
            begin
                r.cnt = 4'h0;
                if (!line)
                    r.st = RX_START;
            end
            RX_START:
            begin
                if (s.cnt == HALF_LAST)
                begin
                    r.cnt = 4'h0;
                    r.bitn = 3'h0;
                    r.st = line ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (s.cnt == BIT_LAST)
                begin
                    r.cnt = 4'h0;
                    r.sh = {line, s.sh[7:1]};
                    r.bitn = s.bitn + 3'h1;
                    if (s.bitn == DATA_LAST)
                        r.st = RX_STOP;
                end
            end
            default:
            begin
                if (s.cnt == BIT_LAST)
                begin
                    r.st = RX_IDLE;
                    r.done = line;
                    r.ferr = !line;
                end
            end
        endcase
        rx_step = r;
    endfunction

    function automatic esl_tx_t tx_load(input logic [7:0] b);
        esl_tx_t t;
        t.busy = 1'b1;
        t.cnt = 4'h0;
        t.bitn = 4'h0;
        t.sh = {1'b1, b, 1'b0};
        t.done = 1'b0;
        tx_load = t;
    endfunction

    // One clock of the byte sender; sh[0] is the bit on the line
    function automatic esl_tx_t tx_step(input esl_tx_t s);
        esl_tx_t t;
        t = s;
        t.done = 1'b0;
        if (s.busy)
        begin
            t.cnt = s.cnt + 4'h1;
            if (s.cnt == BIT_LAST)
            begin
                t.cnt = 4'h0;
                t.sh = {1'b1, s.sh[9:1]};
                t.bitn = s.bitn + 4'h1;
                if (s.bitn == FRAME_LAST)
                begin
                    t.busy = 1'b0;
                    t.done = 1'b1;
                end
            end
        end
        tx_step = t;
    endfunction
endpackage

// ---- design/esl_link_if.sv ----
`timescale 1ns/1ps
interface esl_link_if;
    logic ctl_tx;
    logic ctl_oe_n;
    logic enc_tx;
    logic enc_oe_n;
    wire  line;
    // Fail-safe bias holds the undriven line at one
    assign line = !ctl_oe_n ? ctl_tx : (!enc_oe_n ? enc_tx : 1'b1);
    modport ctl (output ctl_tx, output ctl_oe_n, input line);
    modport enc (output enc_tx, output enc_oe_n, input line);
endinterface

// ---- design/esl_encoder.sv ----
`timescale 1ns/1ps
// Operation
// - Bytes: start, eight data LSB first, stop
// - Bits run at 2.5 Mbps
// - Last byte is XOR of frame; checked
// - User bytes at addresses 0 to 0x7E
// - Address 0x7F selects page 0 to 2
// - Memory reply: command, address, content, checksum
// - First byte names the command type
// - Position in 23 bits or 17-bit variant
// - Revolution count sent as 24 bits, top byte zero
// - Reply within 20 us; master stays silent
module esl_encoder (
    // Clock and reset
    input  logic       clock,
    input  logic       resetn,
    // Link
    esl_link_if.enc    link,
    // Position source
    input  logic [22:0] pos_single,
    input  logic       res_23,
    input  logic [15:0] turns,
    input  logic       cnt_err,
    input  logic       mt_err,
    input  logic [7:0] alarm_code,
    // Frame reports
    output logic [7:0] last_cmd,
    output logic       frame_pulse,
    output logic       err_pulse,
    output logic [1:0] page_sel
);
    typedef enum logic [1:0] {PH_RX, PH_TURN, PH_TX} esl_ph_t;
    typedef struct packed {
        esl_ph_t          ph;
        esl_pkg::esl_rx_t rx;
        esl_pkg::esl_tx_t tx;
        logic [3:0][7:0]  rq;
        logic [3:0]       nrx;
        logic [7:0]       acc;
        logic [8:0]       tmr;
        esl_pkg::esl_buf_t tb;
        logic [3:0]       tlen;
        logic [3:0]       tidx;
        logic [1:0]       page;
        logic [7:0]       cmd;
        logic             frame;
        logic             err;
        logic             line;
        logic             oe_n;
    } esl_enc_t;

    esl_enc_t          s_ff;
    esl_enc_t          nxt_s;
    logic [7:0]        mem [0:esl_pkg::PAGES*esl_pkg::NV_WORDS-1];
    logic              wr_en;
    logic [8:0]        wr_idx;
    logic [7:0]        wr_dat;
    logic [7:0]        b;
    logic [7:0]        c;
    logic [6:0]        ad;
    logic [7:0]        dt;
    logic [8:0]        idx;
    logic [23:0]       abs24;
    logic [7:0]        sf;
    logic [3:0]        len;
    esl_pkg::esl_buf_t tb;

    function automatic logic [8:0] nv_index(input logic [1:0] pg, input logic [6:0] a);
        nv_index = 9'(pg) * 9'(esl_pkg::NV_WORDS) + 9'(a);
    endfunction

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.frame = 1'b0;
        nxt_s.err = 1'b0;
        wr_en = 1'b0;
        wr_idx = 9'h000;
        wr_dat = 8'h00;
        b = s_ff.rx.sh;
        c = s_ff.rq[0];
        ad = s_ff.rq[1][6:0];
        dt = s_ff.rq[2];
        idx = nv_index(s_ff.page, ad);
        abs24 = 24'h00_0000;
        sf = 8'h00;
        len = esl_pkg::rsp_len(c);
        tb = '0;
        case (s_ff.ph)
            PH_RX:
            begin
                nxt_s.rx = esl_pkg::rx_step(s_ff.rx, link.line);
                b = nxt_s.rx.sh;
                if (s_ff.nrx == 4'h0 || s_ff.rx.st != esl_pkg::RX_IDLE)
                    nxt_s.tmr = 9'h000;
                else
                    nxt_s.tmr = s_ff.tmr + 9'h001;
                if (nxt_s.rx.ferr || s_ff.tmr == esl_pkg::REPLY_LAST)
                begin
                    // Bad stop bit or a stalled frame drops the partial frame
                    nxt_s.nrx = 4'h0;
                    nxt_s.acc = 8'h00;
                    nxt_s.tmr = 9'h000;
                    nxt_s.err = 1'b1;
                end
                else if (nxt_s.rx.done)
                begin
                    nxt_s.rq[s_ff.nrx[1:0]] = b;
                    nxt_s.acc = s_ff.acc ^ b;
                    nxt_s.nrx = s_ff.nrx + 4'h1;
                    if (s_ff.nrx == 4'h0 && esl_pkg::req_len(b) == 4'h0)
                    begin
                        // Unknown first byte is not a frame start
                        nxt_s.nrx = 4'h0;
                        nxt_s.acc = 8'h00;
                    end
                    else if (s_ff.nrx != 4'h0 && s_ff.nrx + 4'h1 == esl_pkg::req_len(c))
                    begin
                        nxt_s.nrx = 4'h0;
                        nxt_s.acc = 8'h00;
                        if ((s_ff.acc ^ b) != 8'h00)
                            nxt_s.err = 1'b1;
                        else
                        begin
                            nxt_s.ph = PH_TURN;
                            nxt_s.cmd = c;
                            nxt_s.frame = 1'b1;
                        end
                    end
                end
            end
            PH_TURN:
            begin
                // One bit time lets the master release the line first
                nxt_s.tmr = s_ff.tmr + 9'h001;
                if (s_ff.tmr == esl_pkg::TURN_LAST)
                begin
                    abs24 = res_23 ? {1'b0, pos_single} :
                            24'(pos_single >> esl_pkg::ABS17_SHIFT);
                    sf[esl_pkg::SF_CNT_ERR] = cnt_err;
                    sf[esl_pkg::SF_MT_ERR] = mt_err;
                    tb[0] = c;
                    case (c)
                        esl_pkg::CMD_POS:
                        begin
                            tb[1] = sf;
                            tb[4:2] = abs24;
                        end
                        esl_pkg::CMD_TURNS:
                            tb[3:1] = {8'h00, turns};
                        esl_pkg::CMD_ID:
                            tb[1] = res_23 ? esl_pkg::ENID_23 : esl_pkg::ENID_17;
                        esl_pkg::CMD_ALL:
                        begin
                            tb[1] = sf;
                            tb[4:2] = abs24;
                            tb[5] = res_23 ? esl_pkg::ENID_23 : esl_pkg::ENID_17;
                            tb[8:6] = {8'h00, turns};
                            tb[9] = alarm_code;
                        end
                        default:
                        begin
                            tb[1] = s_ff.rq[1];
                            if (ad == esl_pkg::PAGE_ADDR)
                            begin
                                if (c == esl_pkg::CMD_NV_WR && dt <= esl_pkg::PAGE_MAX)
                                    nxt_s.page = dt[1:0];
                                tb[2] = {6'h00, nxt_s.page};
                            end
                            else if (c == esl_pkg::CMD_NV_WR)
                            begin
                                wr_en = 1'b1;
                                wr_idx = idx;
                                wr_dat = dt;
                                tb[2] = dt;
                            end
                            else
                                tb[2] = mem[idx];
                        end
                    endcase
                    tb[len - 4'h1] = esl_pkg::cksum(tb, len);
                    nxt_s.tb = tb;
                    nxt_s.tlen = len;
                    nxt_s.tidx = 4'h0;
                    nxt_s.tx = esl_pkg::tx_load(tb[0]);
                    nxt_s.ph = PH_TX;
                end
            end
            default:
            begin
                nxt_s.tx = esl_pkg::tx_step(s_ff.tx);
                if (nxt_s.tx.done)
                begin
                    if (s_ff.tidx + 4'h1 == s_ff.tlen)
                    begin
                        nxt_s.ph = PH_RX;
                        nxt_s.rx = '0;
                        nxt_s.tmr = 9'h000;
                    end
                    else
                    begin
                        nxt_s.tidx = s_ff.tidx + 4'h1;
                        nxt_s.tx = esl_pkg::tx_load(s_ff.tb[s_ff.tidx + 4'h1]);
                    end
                end
            end
        endcase
        nxt_s.line = nxt_s.tx.busy ? nxt_s.tx.sh[0] : 1'b1;
        nxt_s.oe_n = !nxt_s.tx.busy;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_ff <= '0;
            s_ff.page <= esl_pkg::PAGE_RST;
            s_ff.line <= 1'b1;
            s_ff.oe_n <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    // User storage keeps no reset value; it stands for the nonvolatile array
    always_ff @(posedge clock)
    begin
        if (wr_en)
            mem[wr_idx] <= wr_dat;
    end

    assign link.enc_tx = s_ff.line;
    assign link.enc_oe_n = s_ff.oe_n;
    assign last_cmd = s_ff.cmd;
    assign frame_pulse = s_ff.frame;
    assign err_pulse = s_ff.err;
    assign page_sel = s_ff.page;
endmodule

// ---- design/esl_master.sv ----
`timescale 1ns/1ps
module esl_master (
    // Clock and reset
    input  logic       clock,
    input  logic       resetn,
    // Link
    esl_link_if.ctl    link,
    // Request
    input  logic       req,
    input  logic [7:0] req_cmd,
    input  logic [7:0] req_addr,
    input  logic [7:0] req_data,
    // Answer
    output logic       busy,
    output logic       done,
    output logic       rsp_err,
    output logic       timeout,
    output logic [3:0] rsp_n,
    output esl_pkg::esl_buf_t rsp
);
    typedef enum logic [1:0] {C_IDLE, C_TX, C_RX} esl_cst_t;
    typedef struct packed {
        esl_cst_t          st;
        esl_pkg::esl_rx_t  rx;
        esl_pkg::esl_tx_t  tx;
        esl_pkg::esl_buf_t tb;
        esl_pkg::esl_buf_t rsp;
        logic [3:0]        tlen;
        logic [3:0]        tidx;
        logic [3:0]        n;
        logic [3:0]        rsp_n;
        logic [7:0]        cmd;
        logic [7:0]        acc;
        logic [8:0]        tmr;
        logic              busy;
        logic              done;
        logic              err;
        logic              tmo;
        logic              line;
        logic              oe_n;
    } esl_ctl_t;

    esl_ctl_t          s_ff;
    esl_ctl_t          nxt_s;
    esl_pkg::esl_buf_t tb;
    logic [3:0]        len;
    logic [7:0]        b;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        tb = '0;
        len = esl_pkg::req_len(req_cmd);
        b = 8'h00;
        case (s_ff.st)
            C_IDLE:
            begin
                // Let the far end finish its stop bit before driving the line
                if (s_ff.tmr != 9'h000)
                    nxt_s.tmr = s_ff.tmr - 9'h001;
                else if (req && len != 4'h0)
                begin
                    tb[0] = req_cmd;
                    tb[1] = req_addr;
                    tb[2] = req_data;
                    tb[len - 4'h1] = esl_pkg::cksum(tb, len);
                    nxt_s.tb = tb;
                    nxt_s.tlen = len;
                    nxt_s.tidx = 4'h0;
                    nxt_s.cmd = req_cmd;
                    nxt_s.tx = esl_pkg::tx_load(req_cmd);
                    nxt_s.busy = 1'b1;
                    nxt_s.err = 1'b0;
                    nxt_s.tmo = 1'b0;
                    nxt_s.st = C_TX;
                end
            end
            C_TX:
            begin
                nxt_s.tx = esl_pkg::tx_step(s_ff.tx);
                if (nxt_s.tx.done)
                begin
                    if (s_ff.tidx + 4'h1 == s_ff.tlen)
                    begin
                        nxt_s.st = C_RX;
                        nxt_s.rx = '0;
                        nxt_s.tmr = 9'h000;
                        nxt_s.n = 4'h0;
                        nxt_s.acc = 8'h00;
                        nxt_s.rsp = '0;
                    end
                    else
                    begin
                        nxt_s.tidx = s_ff.tidx + 4'h1;
                        nxt_s.tx = esl_pkg::tx_load(s_ff.tb[s_ff.tidx + 4'h1]);
                    end
                end
            end
            default:
            begin
                // Nothing is sent until the reply ends or the wait runs out
                nxt_s.rx = esl_pkg::rx_step(s_ff.rx, link.line);
                b = nxt_s.rx.sh;
                nxt_s.tmr = (s_ff.rx.st != esl_pkg::RX_IDLE) ? 9'h000 : s_ff.tmr + 9'h001;
                if (nxt_s.rx.ferr || s_ff.tmr == esl_pkg::REPLY_LAST)
                begin
                    nxt_s.err = nxt_s.rx.ferr;
                    nxt_s.tmo = !nxt_s.rx.ferr;
                    nxt_s.rsp_n = s_ff.n;
                    nxt_s.tmr = 9'(esl_pkg::HALF_LAST);
                    nxt_s.done = 1'b1;
                    nxt_s.busy = 1'b0;
                    nxt_s.st = C_IDLE;
                end
                else if (nxt_s.rx.done)
                begin
                    nxt_s.rsp[s_ff.n] = b;
                    nxt_s.acc = s_ff.acc ^ b;
                    nxt_s.n = s_ff.n + 4'h1;
                    nxt_s.tmr = 9'h000;
                    if (s_ff.n + 4'h1 == esl_pkg::rsp_len(s_ff.cmd))
                    begin
                        nxt_s.err = (s_ff.acc ^ b) != 8'h00 || s_ff.rsp[0] != s_ff.cmd;
                        nxt_s.rsp_n = s_ff.n + 4'h1;
                        nxt_s.tmr = 9'(esl_pkg::HALF_LAST);
                        nxt_s.done = 1'b1;
                        nxt_s.busy = 1'b0;
                        nxt_s.st = C_IDLE;
                    end
                end
            end
        endcase
        nxt_s.line = nxt_s.tx.busy ? nxt_s.tx.sh[0] : 1'b1;
        nxt_s.oe_n = !nxt_s.tx.busy;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_ff <= '0;
            s_ff.line <= 1'b1;
            s_ff.oe_n <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    assign link.ctl_tx = s_ff.line;
    assign link.ctl_oe_n = s_ff.oe_n;
    assign busy = s_ff.busy;
    assign done = s_ff.done;
    assign rsp_err = s_ff.err;
    assign timeout = s_ff.tmo;
    assign rsp_n = s_ff.rsp_n;
    assign rsp = s_ff.rsp;
endmodule

// ---- tb/esl_link_sva.sv ----
`timescale 1ns/1ps
module esl_link_sva (
    // Clock and reset
    input logic clock,
    input logic resetn,
    // Link
    input logic ctl_tx,
    input logic ctl_oe_n,
    input logic enc_tx,
    input logic enc_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // Cycles since the master began driving, modulo one bit time
    logic [2:0] ph_ff;
    logic [2:0] nxt_ph;
    always_comb nxt_ph = ctl_oe_n ? 3'h0 : ph_ff + 3'h1;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            ph_ff <= 3'h0;
        else
            ph_ff <= nxt_ph;
    end
    property p_start_ctl; $fell(ctl_oe_n) |-> !ctl_tx [*8]; endproperty
    a_start_ctl: assert property (p_start_ctl) else $error("master start bit");
    property p_start_enc; $fell(enc_oe_n) |-> !enc_tx [*8]; endproperty
    a_start_enc: assert property (p_start_enc) else $error("encoder start bit");
    property p_stop_ctl; $rose(ctl_oe_n) |-> $past(ctl_tx); endproperty
    a_stop_ctl: assert property (p_stop_ctl) else $error("master stop bit");
    property p_stop_enc; $rose(enc_oe_n) |-> $past(enc_tx); endproperty
    a_stop_enc: assert property (p_stop_enc) else $error("encoder stop bit");
    property p_bit_phase;
        !ctl_oe_n && !$fell(ctl_oe_n) && $changed(ctl_tx) |-> ph_ff == 3'h0;
    endproperty
    a_bit_phase: assert property (p_bit_phase) else $error("master bit width");
    property p_no_overlap; !(!ctl_oe_n && !enc_oe_n); endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("both drive");
    property p_reply_wait; $rose(ctl_oe_n) |-> ##[1:400] $fell(enc_oe_n); endproperty
    a_reply_wait: assert property (p_reply_wait) else $error("reply late");
    property p_quiet; $rose(ctl_oe_n) |-> ctl_oe_n [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("master not silent");
endmodule

// ---- tb/test_encoder_serial_frame_link.sv ----
`timescale 1ns/1ps
module test_encoder_serial_frame_link;
    logic              clock = 1'b0;
    logic              resetn = 1'b0;
    logic              req = 1'b0;
    logic [7:0]        req_cmd = 8'h00;
    logic [7:0]        req_addr = 8'h00;
    logic [7:0]        req_data = 8'h00;
    logic [22:0]       pos_single = 23'h5A_3C81;
    logic              res_23 = 1'b1;
    logic [15:0]       turns = 16'hBEEF;
    logic              cnt_err = 1'b1;
    logic              mt_err = 1'b0;
    logic [7:0]        alarm_code = 8'h6D;
    logic              busy, done, rsp_err, timeout, frame_pulse, err_pulse;
    logic [3:0]        rsp_n;
    esl_pkg::esl_buf_t rsp;
    logic [7:0]        last_cmd;
    logic [1:0]        page_sel;
    logic [7:0]        e[$];
    logic [31:0]       nv[11];
    int                mismatches, num_checks, frames, ntx, errs;
    always #25 clock = ~clock;
    always @(posedge clock) if (frame_pulse === 1'b1) frames++;
    always @(posedge clock) if (err_pulse === 1'b1) errs++;
    esl_link_if esl_link_if_inst ();
    esl_master esl_master_inst (.clock(clock), .resetn(resetn), .link(esl_link_if_inst),
        .req(req), .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data), .busy(busy),
        .done(done), .rsp_err(rsp_err), .timeout(timeout), .rsp_n(rsp_n), .rsp(rsp));
    esl_encoder esl_encoder_inst (.clock(clock), .resetn(resetn), .link(esl_link_if_inst),
        .pos_single(pos_single), .res_23(res_23), .turns(turns), .cnt_err(cnt_err),
        .mt_err(mt_err), .alarm_code(alarm_code), .last_cmd(last_cmd),
        .frame_pulse(frame_pulse), .err_pulse(err_pulse), .page_sel(page_sel));
    esl_link_sva esl_link_sva_inst (.clock(clock), .resetn(resetn),
        .ctl_tx(esl_link_if_inst.ctl_tx), .ctl_oe_n(esl_link_if_inst.ctl_oe_n),
        .enc_tx(esl_link_if_inst.enc_tx), .enc_oe_n(esl_link_if_inst.enc_oe_n));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One transaction; x is the expected memory content for nonvolatile commands
    task automatic txn(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] x);
        int         n;
        logic [7:0] ck;
        logic [9:0] fr;
        logic [7:0] sf;
        logic [7:0] id;
        logic [23:0] ab;
        fr = {1'b1, c, 1'b0};
        sf = {2'b00, mt_err, cnt_err, 4'h0};
        id = res_23 ? esl_pkg::ENID_23 : esl_pkg::ENID_17;
        ab = res_23 ? {1'b0, pos_single} : {7'h00, pos_single[22:6]};
        case (c)
            esl_pkg::CMD_POS: e = '{c, sf, ab[7:0], ab[15:8], ab[23:16]};
            esl_pkg::CMD_TURNS: e = '{c, turns[7:0], turns[15:8], 8'h00};
            esl_pkg::CMD_ID: e = '{c, id};
            esl_pkg::CMD_ALL: e = '{c, sf, ab[7:0], ab[15:8], ab[23:16], id, turns[7:0],
                                    turns[15:8], 8'h00, alarm_code};
            default: e = '{c, a, x};
        endcase
        ck = 8'h00;
        foreach (e[i]) ck = ck ^ e[i];
        e.push_back(ck);
        @(negedge clock);
        req = 1'b1;
        req_cmd = c;
        req_addr = a;
        req_data = d;
        n = 0;
        while (esl_link_if_inst.ctl_oe_n !== 1'b0 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        req = 1'b0;
        repeat (3) @(negedge clock);
        for (int i = 0; i < 10; i++)
        begin
            chk("wire bit", esl_link_if_inst.line, fr[i]);
            repeat (8) @(negedge clock);
        end
        n = 0;
        while (done !== 1'b1 && n < 2000)
        begin
            @(negedge clock);
            n++;
        end
        ntx++;
        chk("done", done, 1'b1);
        chk("reply length", rsp_n, e.size());
        chk("reply error", {rsp_err, timeout}, 2'b00);
        foreach (e[i]) chk("reply byte", rsp[i], e[i]);
        chk("last command", last_cmd, c);
    endtask

    initial
    begin
        #2_000_000;
        mismatches++;
        results();
    end

    initial
    begin
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            txn(esl_pkg::CMD_POS, 8'h00, 8'h00, 8'h00);
            txn(esl_pkg::CMD_TURNS, 8'h00, 8'h00, 8'h00);
            txn(esl_pkg::CMD_ID, 8'h00, 8'h00, 8'h00);
            txn(esl_pkg::CMD_ALL, 8'h00, 8'h00, 8'h00);
            res_23 = 1'b0;
            cnt_err = 1'b0;
            mt_err = 1'b1;
            pos_single = 23'h7F_FFC3;
            turns = 16'h0102;
        end
        nv = '{32'h327F_0202, 32'h327F_0302, 32'h3210_A5A5, 32'h327F_0000,
               32'h3210_3C3C, 32'h327E_8181, 32'hEA10_003C, 32'hEA7E_0081,
               32'h327F_0202, 32'hEA10_00A5, 32'hEA7F_0002};
        foreach (nv[i])
        begin
            txn(nv[i][31:24], nv[i][23:16], nv[i][15:8], nv[i][7:0]);
            if (nv[i][23:16] == 8'h7F)
                chk("page", page_sel, nv[i][1:0]);
        end
        @(negedge clock);
        req_cmd = 8'h2B;
        req = 1'b1;
        repeat (3) @(negedge clock);
        chk("unknown busy", busy, 1'b0);
        chk("unknown idle", esl_link_if_inst.line, 1'b1);
        req = 1'b0;
        repeat (20) @(negedge clock);
        chk("frames taken", frames, ntx);
        chk("frames dropped", errs, 0);
        results();
    end
endmodule
